// File: hdl/lsc_byte_engine.sv
// Byte engine: one start bit, eight data bits LSB first, one stop bit, in either direction
`timescale 1ns/10ps
module lsc_byte_engine (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [16:0] bit_len_i,
  input wire logic [16:0] short_lim_i,
  input wire logic rx_i,
  input wire logic start_rx_i,
  input wire logic start_tx_i,
  input wire logic [7:0] tx_byte_i,
  output logic done_o,
  output logic [7:0] byte_o,
  output logic stop_missing_o,
  output logic stop_short_o,
  output logic tx_o
);
  import lsc_pkg::*;

  typedef struct packed {
    lsc_eng_t st;
    logic [16:0] cnt;
    logic [3:0] idx;
    logic [9:0] sh;
    logic txm;
    logic tx;
    logic done;
    logic miss;
    logic shrt;
    logic lowstop;
  } lsc_eng_state_t;

  lsc_eng_state_t s_q;
  lsc_eng_state_t s_d;
  logic [16:0] half;
  logic [16:0] last;

  assign half = bit_len_i >> 1;
  assign last = bit_len_i - 17'h00001;

  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.miss = 1'b0;
    s_d.shrt = 1'b0;
    // A stop seen low must rise again before a new start counts
    if (rx_i)
      s_d.lowstop = 1'b0;
    unique case (s_q.st)
      ENG_IDLE:
      begin
        if (start_tx_i)
        begin
          s_d.st = ENG_BITS;
          s_d.txm = 1'b1;
          s_d.sh = {1'b1, tx_byte_i, 1'b0};
          s_d.tx = 1'b0;
          s_d.cnt = '0;
          s_d.idx = '0;
        end
        else if (start_rx_i)
        begin
          s_d.st = ENG_WAIT;
          s_d.txm = 1'b0;
        end
      end
      ENG_WAIT:
      begin
        // Level, not edge: a stop bit cut short still leaves the next start visible
        if (!rx_i && !s_q.lowstop)
        begin
          s_d.st = ENG_BITS;
          s_d.cnt = '0;
          s_d.idx = '0;
        end
      end
      ENG_BITS:
      begin
        s_d.cnt = s_q.cnt + 17'h00001;
        if (s_q.cnt == half)
        begin
          if (!s_q.txm)
            s_d.sh = {rx_i, s_q.sh[9:1]};
          if (s_q.idx == STOP_IDX)
          begin
            s_d.miss = !rx_i;
            if (!rx_i)
            begin
              s_d.st = ENG_IDLE;
              s_d.done = 1'b1;
              s_d.lowstop = 1'b1;
            end
            else if (!s_q.txm)
              s_d.st = ENG_STOP;
          end
        end
        if (s_q.cnt == last)
        begin
          s_d.cnt = '0;
          s_d.idx = s_q.idx + 4'h1;
          if (s_q.txm)
          begin
            s_d.sh = {1'b1, s_q.sh[9:1]};
            s_d.tx = s_q.sh[1];
            if (s_q.idx == STOP_IDX)
            begin
              s_d.st = ENG_IDLE;
              s_d.done = 1'b1;
              s_d.tx = 1'b1;
            end
          end
        end
      end
      ENG_STOP:
      begin
        s_d.cnt = s_q.cnt + 17'h00001;
        if (!rx_i)
        begin
          s_d.shrt = 1'b1;
          s_d.st = ENG_IDLE;
          s_d.done = 1'b1;
        end
        else if (s_q.cnt >= short_lim_i)
        begin
          s_d.st = ENG_IDLE;
          s_d.done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.st <= ENG_IDLE;
      s_q.tx <= 1'b1;
    end
    else if (clk_en_i)
      s_q <= s_d;
  end

  assign done_o = s_q.done;
  assign byte_o = s_q.sh[8:1];
  assign stop_missing_o = s_q.miss;
  assign stop_short_o = s_q.shrt;
  assign tx_o = s_q.tx;

  stop_missing_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && s_q.st == ENG_BITS && s_q.idx == STOP_IDX && s_q.cnt == half && !rx_i
    |=> stop_missing_o && done_o)
    else $error("low stop level not reported");
  stop_short_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && s_q.st == ENG_STOP && !rx_i |=> stop_short_o ##1 !stop_short_o)
    else $error("short stop bit not reported once");
endmodule : lsc_byte_engine

// File: hdl/lsc_link_ctrl.sv
// Link controller: break, sync measurement, identifier and data bytes, error log and registers
// Notes on behaviour
// - direction bit picks receive or transmit
// - error log read-only, resets zero
// - bit 6 flags short break delimiter
// - bit 5 flags sync longer than expected
// - bit 4 flags sync shorter than expected
// - bit 3 flags short stop bit
// - bit 2 flags low stop level
// - bit 1 flags identifier parity error
// - sync width high byte readable
// - error log clears only between frames
// - stop tolerance 15 percent, doubled 30
// - byte count loaded first, at most eight
// - sync width low byte readable
`timescale 1ns/10ps
module lsc_link_ctrl #(
  parameter int NOM_BIT_CYC = lsc_pkg::NOM_BIT_CYC_DEF
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic lin_rx_i,
  output logic lin_tx_o,
  output logic irq_o
);
  import lsc_pkg::*;

  localparam logic [20:0] NOM_CYC = 21'(NOM_BIT_CYC);
  localparam logic [20:0] BREAK_CYC = 21'(NOM_BIT_CYC * BREAK_MIN_BITS);
  localparam int SYNC_EXP = (NOM_BIT_CYC * SYNC_BITS) >> SYNC_TICK_SHIFT;
  localparam logic [15:0] SYNC_LONG_LIM = 16'(SYNC_EXP + SYNC_EXP * SYNC_TOL_PCT / 100);
  localparam logic [15:0] SYNC_SHORT_LIM = 16'(SYNC_EXP - SYNC_EXP * SYNC_TOL_PCT / 100);

  typedef struct packed {
    logic [2:0] rx_sync;
    lsc_state_t st;
    logic [20:0] cnt;
    logic [2:0] edges;
    logic [15:0] sync_cnt;
    logic [16:0] bit_len;
    logic [3:0] idx;
    logic [7:0] sum;
    logic [7:0] pid;
    logic dir;
    logic mode;
    logic [7:0] cfg;
    logic [3:0] count;
    logic [7:0][7:0] txbuf;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic start_rx;
    logic start_tx;
    logic [7:0] tx_byte;
  } lsc_ctrl_state_t;

  lsc_ctrl_state_t s_q;
  lsc_ctrl_state_t s_d;

  logic rx;
  logic rx_fall;
  logic eng_done;
  logic [7:0] eng_byte;
  logic eng_miss;
  logic eng_short;
  logic [7:0] err_set;
  logic [7:0] err_clr;
  logic [7:0] err_log;
  logic [7:0] irq_set;
  logic [7:0] irq_clr;
  logic [7:0] irq_stat;
  logic [23:0] tol_prod;
  logic [16:0] short_lim;
  logic [7:0] cs_in;
  logic [8:0] cs_raw;
  logic [7:0] cs_next;
  logic par_ok;
  logic [20:0] cnt_sh;
  logic [15:0] ticks;
  logic sync_evt;
  logic in_txbuf;
  logic [2:0] buf_idx;

  // Second stage is the only reader of the first
  assign rx = s_q.rx_sync[1];
  assign rx_fall = s_q.rx_sync[2] & !rx;

  assign tol_prod = s_q.bit_len * (s_q.cfg[CFG_TOL_BIT] ? STOP_TOL_DBL_PCT : STOP_TOL_PCT);
  assign short_lim = s_q.bit_len - 17'(tol_prod / PCT_DIV);

  assign cs_in = (s_q.st == ST_TXD) ? s_q.tx_byte : eng_byte;
  assign cs_raw = {1'b0, s_q.sum} + {1'b0, cs_in};
  assign cs_next = cs_raw[7:0] + {7'h00, cs_raw[8]};
  assign par_ok = (eng_byte[6] == (eng_byte[0] ^ eng_byte[1] ^ eng_byte[2] ^ eng_byte[4]))
    && (eng_byte[7] == !(eng_byte[1] ^ eng_byte[3] ^ eng_byte[4] ^ eng_byte[5]));

  // Width counted in ticks so a 16-bit field covers the whole sync byte
  assign cnt_sh = s_q.cnt >> SYNC_TICK_SHIFT;
  assign ticks = (|cnt_sh[20:16]) ? 16'hffff : cnt_sh[15:0];
  assign sync_evt = (s_q.st == ST_SYNC) && rx_fall && (s_q.edges == SYNC_EDGES - 3'h1);

  assign in_txbuf = (reg_addr_i >= ADDR_TXBUF_FIRST) && (reg_addr_i <= ADDR_TXBUF_LAST);
  assign buf_idx = 3'(reg_addr_i - ADDR_TXBUF_FIRST);

  assign err_clr = {8{s_q.cfg[CFG_CLR_BIT] && (s_q.st == ST_IDLE)}};
  assign irq_clr = (reg_wr_i && reg_addr_i == ADDR_IRQ_STAT) ? reg_wdata_i : 8'h00;

  always_comb
  begin
    logic go_rx;
    logic go_tx;
    logic fin;
    logic [3:0] nidx;
    go_rx = 1'b0;
    go_tx = 1'b0;
    fin = 1'b0;
    nidx = 4'h0;
    s_d = s_q;
    s_d.rx_sync = {s_q.rx_sync[1:0], lin_rx_i};
    s_d.start_rx = 1'b0;
    s_d.start_tx = 1'b0;
    s_d.rdata = 8'h00;
    err_set = 8'h00;
    irq_set = 8'h00;

    if (reg_wr_i)
    begin
      if (in_txbuf)
        s_d.txbuf[buf_idx] = reg_wdata_i;
      case (reg_addr_i)
        // only the direction bit is kept
        ADDR_CTRL: s_d.dir = reg_wdata_i[CTRL_DIR_BIT];
        ADDR_CFG: s_d.cfg = reg_wdata_i;
        ADDR_COUNT: s_d.count = (reg_wdata_i[3:0] > MAX_COUNT) ? MAX_COUNT : reg_wdata_i[3:0];
        ADDR_MODE: s_d.mode = reg_wdata_i[MODE_SCI_BIT];
        ADDR_IRQ_MASK: s_d.irq_mask = reg_wdata_i;
        default: s_d.irq_mask = s_q.irq_mask;
      endcase
    end

    if (reg_rd_i)
    begin
      if (in_txbuf)
        s_d.rdata = s_q.txbuf[buf_idx];
      else
        case (reg_addr_i)
          ADDR_PID: s_d.rdata = s_q.pid;
          ADDR_COUNT: s_d.rdata = {4'h0, s_q.count};
          ADDR_CFG: s_d.rdata = s_q.cfg;
          ADDR_CTRL: s_d.rdata = {7'h00, s_q.dir};
          ADDR_ERRLOG: s_d.rdata = err_log;
          ADDR_SYNC_HI: s_d.rdata = s_q.sync_cnt[15:8];
          ADDR_SYNC_LO: s_d.rdata = s_q.sync_cnt[7:0];
          ADDR_MODE: s_d.rdata = {7'h00, s_q.mode};
          ADDR_IRQ_STAT: s_d.rdata = irq_stat;
          ADDR_IRQ_MASK: s_d.rdata = s_q.irq_mask;
          default: s_d.rdata = 8'h00;
        endcase
    end

    if (s_q.st != ST_BREAK && s_q.cnt != {21{1'b1}})
      s_d.cnt = s_q.cnt + 21'h000001;
    err_set[ERR_STOP_MISSING] = eng_miss;
    err_set[ERR_STOP_SHORT] = eng_short;

    unique case (s_q.st)
      ST_IDLE:
      begin
        s_d.cnt = '0;
        if (s_q.mode)
        begin
          // plain serial starts on a control write
          if (reg_wr_i && reg_addr_i == ADDR_CTRL)
          begin
            s_d.bit_len = 17'(NOM_BIT_CYC);
            s_d.sum = 8'h00;
            go_tx = reg_wdata_i[CTRL_DIR_BIT];
            go_rx = !reg_wdata_i[CTRL_DIR_BIT];
          end
        end
        else if (rx_fall)
          s_d.st = ST_BREAK;
      end
      ST_BREAK:
      begin
        if (s_q.cnt != {21{1'b1}})
          s_d.cnt = s_q.cnt + 21'h000001;
        if (rx)
        begin
          s_d.st = (s_q.cnt >= BREAK_CYC) ? ST_DELIM : ST_IDLE;
          s_d.cnt = '0;
        end
      end
      ST_DELIM:
      begin
        if (rx_fall)
        begin
          err_set[ERR_BREAK_DELIM] = (s_q.cnt < NOM_CYC);
          s_d.st = ST_SYNC;
          // The edge cycle itself counts, so eight bits give a full width
          s_d.cnt = 21'h000001;
          s_d.edges = 3'h0;
        end
        else if (s_q.cnt >= BREAK_CYC)
          s_d.st = ST_IDLE;
      end
      ST_SYNC:
      begin
        if (rx_fall && s_q.edges != SYNC_EDGES)
          s_d.edges = s_q.edges + 3'h1;
        if (sync_evt)
        begin
          s_d.sync_cnt = ticks;
          s_d.bit_len = {ticks, 1'b0};
          err_set[ERR_SYNC_LONG] = (ticks > SYNC_LONG_LIM);
          err_set[ERR_SYNC_SHORT] = (ticks < SYNC_SHORT_LIM);
        end
        if (s_q.edges == SYNC_EDGES && rx)
        begin
          s_d.st = ST_PID;
          s_d.start_rx = 1'b1;
        end
        else if (s_q.cnt == {21{1'b1}})
          s_d.st = ST_IDLE;
      end
      ST_PID:
      begin
        if (eng_done)
        begin
          s_d.pid = eng_byte;
          err_set[ERR_PARITY] = !par_ok;
          irq_set[IRQ_PID] = 1'b1;
          s_d.sum = s_q.cfg[CFG_CS_BIT] ? eng_byte : 8'h00;
          go_tx = s_q.dir;
          go_rx = !s_q.dir;
        end
      end
      ST_DATA:
      begin
        if (eng_done)
        begin
          if (s_q.idx < s_q.count)
          begin
            s_d.sum = cs_next;
            nidx = s_q.idx + 4'h1;
            go_rx = 1'b1;
          end
          else
          begin
            // Received checksum added to the running sum must give all ones
            err_set[ERR_CHECKSUM] = (cs_next != 8'hff);
            fin = 1'b1;
          end
        end
      end
      ST_TXD:
      begin
        if (eng_done)
        begin
          if (s_q.idx < s_q.count)
          begin
            s_d.sum = cs_next;
            nidx = s_q.idx + 4'h1;
            go_tx = 1'b1;
          end
          else
            fin = 1'b1;
        end
      end
    endcase

    s_d.idx = (go_rx || go_tx) ? nidx : s_d.idx;
    if (go_rx)
    begin
      if (nidx < s_q.count || (nidx == s_q.count && !s_q.mode))
      begin
        s_d.st = ST_DATA;
        s_d.start_rx = 1'b1;
      end
      else
        fin = 1'b1;
    end
    if (go_tx)
    begin
      if (nidx < s_q.count)
      begin
        s_d.st = ST_TXD;
        s_d.start_tx = 1'b1;
        s_d.tx_byte = s_q.txbuf[nidx[2:0]];
      end
      else if (nidx == s_q.count && !s_q.mode)
      begin
        s_d.st = ST_TXD;
        s_d.start_tx = 1'b1;
        s_d.tx_byte = ~s_d.sum;
        s_d.idx = nidx + 4'h1;
      end
      else
        fin = 1'b1;
    end
    if (fin)
    begin
      s_d.st = ST_IDLE;
      irq_set[IRQ_DONE] = 1'b1;
    end
    irq_set[IRQ_ERROR] = |err_set;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.rx_sync <= 3'h7;
      s_q.cfg <= CFG_RESET;
    end
    else if (clk_en_i)
      s_q <= s_d;
  end

  lsc_byte_engine u_engine (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .bit_len_i(s_q.bit_len),
    .short_lim_i(short_lim),
    .rx_i(rx),
    .start_rx_i(s_q.start_rx),
    .start_tx_i(s_q.start_tx),
    .tx_byte_i(s_q.tx_byte),
    .done_o(eng_done),
    .byte_o(eng_byte),
    .stop_missing_o(eng_miss),
    .stop_short_o(eng_short),
    .tx_o(lin_tx_o)
  );

  lsc_sticky #(.W(8)) u_err_log (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .set_i(err_set),
    .clr_i(err_clr),
    .flag_o(err_log)
  );

  lsc_sticky #(.W(8)) u_irq_stat (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .set_i(irq_set),
    .clr_i(irq_clr),
    .flag_o(irq_stat)
  );

  assign reg_rdata_o = s_q.rdata;
  assign irq_o = |(irq_stat & s_q.irq_mask);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  ctrl_upper_zero_a: assert property (clk_en_i && reg_rd_i && reg_addr_i == ADDR_CTRL
    |=> reg_rdata_o[7:1] == 7'h00) else $error("control upper bits not zero");
  errlog_read_a: assert property (clk_en_i && reg_rd_i && reg_addr_i == ADDR_ERRLOG
    |=> reg_rdata_o == $past(err_log) ##1 reg_rdata_o == 8'h00 || $past(reg_rd_i))
    else $error("error log readback wrong");
  dir_select_a: assert property (clk_en_i && s_q.st == ST_PID && eng_done && !s_q.mode
    |=> s_q.st == (s_q.dir ? ST_TXD : ST_DATA)) else $error("response direction wrong");
  delim_short_a: assert property (clk_en_i && s_q.st == ST_DELIM && rx_fall && s_q.cnt < NOM_CYC
    |=> err_log[ERR_BREAK_DELIM]) else $error("short delimiter not logged");
  sync_long_a: assert property (clk_en_i && sync_evt && ticks > SYNC_LONG_LIM
    |=> err_log[ERR_SYNC_LONG] && ($past(err_log[ERR_SYNC_SHORT]) || !err_log[ERR_SYNC_SHORT]))
    else $error("long sync not logged");
  sync_short_a: assert property (clk_en_i && sync_evt && ticks < SYNC_SHORT_LIM
    |=> err_log[ERR_SYNC_SHORT]) else $error("short sync not logged");
  parity_log_a: assert property (clk_en_i && s_q.st == ST_PID && eng_done && !par_ok
    |=> err_log[ERR_PARITY]) else $error("parity error not logged");
  sync_width_a: assert property (clk_en_i && sync_evt
    |=> s_q.sync_cnt == $past(ticks) && s_q.bit_len == {$past(ticks), 1'b0})
    else $error("sync width not captured");
  log_clear_a: assert property (clk_en_i && err_clr[0] && err_set == 8'h00
    |=> err_log == 8'h00) else $error("log not cleared between frames");
  log_hold_a: assert property (clk_en_i && !err_clr[0]
    |=> (err_log & $past(err_log)) == $past(err_log)) else $error("error flag dropped");
  count_limit_a: assert property (s_q.count <= MAX_COUNT)
    else $error("byte count above eight");

  rx_frame_c: cover property (s_q.st == ST_DATA && eng_done ##1 s_q.st == ST_IDLE);
  tx_frame_c: cover property (s_q.st == ST_TXD ##[1:1000] s_q.st == ST_IDLE);
  sync_err_c: cover property (sync_evt && ticks > SYNC_LONG_LIM);
  irq_rise_c: cover property ($rose(irq_o));
endmodule : lsc_link_ctrl

// File: hdl/lsc_pkg.sv
// Package: register map, field positions, reset values, timing and state codes of the link controller
package lsc_pkg;
  localparam logic [7:0] ADDR_PID = 8'hd2;
  localparam logic [7:0] ADDR_TXBUF_FIRST = 8'hd3;
  localparam logic [7:0] ADDR_TXBUF_LAST = 8'hda;
  localparam logic [7:0] ADDR_COUNT = 8'hdb;
  localparam logic [7:0] ADDR_CFG = 8'hdc;
  localparam logic [7:0] ADDR_CTRL = 8'hdd;
  localparam logic [7:0] ADDR_ERRLOG = 8'hde;
  localparam logic [7:0] ADDR_SYNC_HI = 8'he3;
  localparam logic [7:0] ADDR_SYNC_LO = 8'he4;
  localparam logic [7:0] ADDR_MODE = 8'hf0;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hf1;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hf2;

  localparam int CTRL_DIR_BIT = 0;
  localparam int MODE_SCI_BIT = 0;
  localparam int CFG_TOL_BIT = 7;
  localparam int CFG_CS_BIT = 6;
  localparam int CFG_CLR_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h40;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int ERR_CHECKSUM = 0;
  localparam int ERR_PARITY = 1;
  localparam int ERR_STOP_MISSING = 2;
  localparam int ERR_STOP_SHORT = 3;
  localparam int ERR_SYNC_SHORT = 4;
  localparam int ERR_SYNC_LONG = 5;
  localparam int ERR_BREAK_DELIM = 6;

  localparam int IRQ_DONE = 0;
  localparam int IRQ_ERROR = 1;
  localparam int IRQ_PID = 2;

  localparam logic [3:0] MAX_COUNT = 4'h8;
  localparam logic [3:0] STOP_IDX = 4'h9;

  localparam int CLK_MHZ = 250;
  localparam int NOM_BIT_US = 50;
  localparam int NOM_BIT_CYC_DEF = NOM_BIT_US * CLK_MHZ;
  localparam int BREAK_MIN_BITS = 11;
  localparam int SYNC_BITS = 8;
  localparam logic [2:0] SYNC_EDGES = 3'h4;
  localparam int SYNC_TICK_SHIFT = 4;
  localparam int SYNC_TOL_PCT = 15;
  localparam logic [6:0] STOP_TOL_PCT = 7'h0f;
  localparam logic [6:0] STOP_TOL_DBL_PCT = 7'h1e;
  localparam logic [23:0] PCT_DIV = 24'h000064;

  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_BREAK = 7'b0000010,
    ST_DELIM = 7'b0000100,
    ST_SYNC = 7'b0001000,
    ST_PID = 7'b0010000,
    ST_DATA = 7'b0100000,
    ST_TXD = 7'b1000000
  } lsc_state_t;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_WAIT = 4'b0010,
    ENG_BITS = 4'b0100,
    ENG_STOP = 4'b1000
  } lsc_eng_t;
endpackage : lsc_pkg

// File: hdl/lsc_sticky.sv
// Sticky flag bank: hardware sets, a clear vector drops bits, a set beats a clear
`timescale 1ns/10ps
module lsc_sticky #(
  parameter int W = 8
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] flag_o
);
  import lsc_pkg::*;

  typedef struct packed {
    logic [W-1:0] flag;
  } lsc_stk_t;

  lsc_stk_t s_q;
  lsc_stk_t s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.flag = (s_q.flag & ~clr_i) | set_i;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else if (clk_en_i)
      s_q <= s_d;
  end

  assign flag_o = s_q.flag;

  set_wins_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    clk_en_i && (|set_i) |=> (flag_o & $past(set_i)) == $past(set_i))
    else $error("set flag lost");
endmodule : lsc_sticky

// File: testbench/lsc_lin_master.sv
// Bus master model: header and bytes onto the bus, reply bytes taken off it
`timescale 1ns/10ps
module lsc_lin_master (
  input wire logic core_clk_i,
  input wire logic bus_i,
  output logic drv_o
);
  initial drv_o = 1'b1;
  task automatic hold(input logic v, input int n);
    drv_o <= v;
    repeat (n) @(posedge core_clk_i);
  endtask : hold
  // Start, eight bits LSB first, stop of chosen length and level
  task automatic put(input logic [7:0] b, input int bt, input int sl, input logic sv);
    hold(1'b0, bt);
    for (int i = 0; i < 8; i++)
      hold(b[i], bt);
    hold(sv, sl);
    if (!sv)
      hold(1'b1, bt);
  endtask : put
  // Break of over twelve nominal bits, so short sync rates still pass the break test
  task automatic head(input int dl, input int bt, input logic [7:0] pid);
    hold(1'b0, 1000);
    hold(1'b1, dl);
    put(8'h55, bt, bt, 1'b1);
    put(pid, bt, bt, 1'b1);
  endtask : head
  // Sampled mid-bit; gives up if no start edge shows
  task automatic get(input int bt, output logic [7:0] b);
    int n;
    n = 0;
    while (bus_i === 1'b1 && n < 2000)
    begin
      @(posedge core_clk_i);
      n++;
    end
    repeat (bt / 2) @(posedge core_clk_i);
    for (int i = 0; i < 8; i++)
    begin
      repeat (bt) @(posedge core_clk_i);
      b[i] = bus_i;
    end
    repeat (bt) @(posedge core_clk_i);
  endtask : get
endmodule : lsc_lin_master

// File: testbench/lsc_link_ctrl_tb_top.sv
// Bench: register reads checked from a queue, frames played by the master model
`timescale 1ns/10ps
module lsc_link_ctrl_tb_top;
  import lsc_pkg::*;
  localparam int BT = 80;
  logic core_clk_i, rst_n_i, reg_wr_i, reg_rd_i, lin_tx_o, irq_o, drv;
  logic rd_seen = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, d0, d1, p, r;
  logic [7:0] exp_q[$];
  int fail_count, checks, cyc;
  wire logic lin_bus = drv & lin_tx_o;
  lsc_link_ctrl #(.NOM_BIT_CYC(BT)) i_lsc_link_ctrl (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .lin_rx_i(lin_bus), .lin_tx_o(lin_tx_o), .irq_o(irq_o));
  lsc_lin_master i_lsc_lin_master (.core_clk_i(core_clk_i), .bus_i(lin_bus), .drv_o(drv));
  initial
  begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = ~core_clk_i;
  end
  task automatic complete_run();
    if (fail_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk_i)
  begin
    rd_seen <= reg_rd_i;
    cyc++;
    if (rd_seen)
      chk("read data", exp_q.pop_front(), reg_rdata_o);
    if (cyc == 60000)
    begin
      fail_count++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    exp_q.push_back(e);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
  endtask : rd
  // Carry-folding sum, inverted
  function automatic logic [7:0] csum(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    logic [9:0] s;
    s = 10'(a) + 10'(b) + 10'(c);
    s = 10'(s[7:0]) + 10'(s[9:8]);
    return ~(s[7:0] + 8'(s[8]));
  endfunction : csum
  function automatic logic [7:0] pid(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : pid
  task automatic frame(input int dl, input int bt, input int sl, input logic pb, input logic cb,
    input logic sv, input logic [7:0] cf, input logic [7:0] ex);
    logic [7:0] d, q;
    d = 8'($urandom);
    q = pid(6'($urandom % 60)) ^ {pb, 7'h00};
    wr(ADDR_CFG, cf | 8'h20);
    wr(ADDR_CFG, cf);
    rd(ADDR_ERRLOG, 8'h00); // cleared while idle
    wr(ADDR_COUNT, 8'h01);
    i_lsc_lin_master.head(dl, bt, q);
    i_lsc_lin_master.put(d, bt, sl, sv);
    i_lsc_lin_master.put(csum(q, d, 8'h00) ^ {7'h00, cb}, bt, bt, 1'b1);
    repeat (bt) @(posedge core_clk_i);
    rd(ADDR_ERRLOG, ex); // frame flags
    rd(ADDR_SYNC_HI, 8'h00); // width high byte
    rd(ADDR_SYNC_LO, 8'(bt / 2)); // width low byte
    rd(ADDR_PID, q); // identifier kept
    rd(ADDR_ERRLOG, ex); // flags held
  endtask : frame
  initial
  begin
    rst_n_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    void'($urandom(51));
    repeat (3) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_CTRL, 8'h00); // control resets zero
    rd(ADDR_ERRLOG, 8'h00); // log resets zero
    rd(ADDR_SYNC_HI, 8'h00); // width resets zero
    rd(ADDR_SYNC_LO, 8'h00); // width resets zero
    rd(ADDR_CFG, CFG_RESET); // tolerance resets normal
    rd(8'hff, 8'h00); // unmapped reads zero
    wr(ADDR_CTRL, 8'hfe);
    rd(ADDR_CTRL, 8'h00); // upper bits ignored
    wr(ADDR_ERRLOG, 8'hff);
    rd(ADDR_ERRLOG, 8'h00); // log read-only
    wr(ADDR_COUNT, 8'h0f);
    rd(ADDR_COUNT, {4'h0, MAX_COUNT}); // count limit
    // A write while the clock enable is low must not land
    clk_en <= 1'b0;
    wr(ADDR_COUNT, 8'h03);
    clk_en <= 1'b1;
    rd(ADDR_COUNT, {4'h0, MAX_COUNT}); // frozen write dropped
    frame(2 * BT, BT, BT, 1'b0, 1'b0, 1'b1, 8'h40, 8'h00); // nominal frame
    // Events stay hidden until unmasked
    @(negedge core_clk_i);
    chk("irq", 8'h00, {7'h00, irq_o}); // masked event hidden
    rd(ADDR_IRQ_STAT, 8'h05); // events held
    wr(ADDR_IRQ_MASK, 8'h07);
    @(negedge core_clk_i);
    chk("irq", 8'h01, {7'h00, irq_o}); // unmasked event shown
    wr(ADDR_IRQ_STAT, 8'h05);
    @(negedge core_clk_i);
    chk("irq", 8'h00, {7'h00, irq_o}); // cleared by writing one
    frame(BT / 2, BT, BT, 1'b0, 1'b0, 1'b1, 8'h40, 8'h40); // short delimiter
    frame(200, 100, 100, 1'b0, 1'b0, 1'b1, 8'h40, 8'h20); // long sync
    frame(128, 64, 64, 1'b0, 1'b0, 1'b1, 8'h40, 8'h10); // short sync
    frame(2 * BT, BT, BT, 1'b1, 1'b0, 1'b1, 8'h40, 8'h02); // parity error
    frame(2 * BT, BT, BT, 1'b0, 1'b1, 1'b1, 8'h40, 8'h01); // checksum error
    frame(2 * BT, BT, BT, 1'b0, 1'b0, 1'b0, 8'h40, 8'h04); // low stop level
    frame(2 * BT, BT, 60, 1'b0, 1'b0, 1'b1, 8'h40, 8'h08); // short stop
    frame(2 * BT, BT, 60, 1'b0, 1'b0, 1'b1, 8'hc0, 8'h00); // doubled tolerance
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    p = pid(6'h11);
    wr(ADDR_TXBUF_FIRST, d0);
    wr(ADDR_TXBUF_FIRST + 8'h01, d1);
    wr(ADDR_COUNT, 8'h02);
    wr(ADDR_CTRL, 8'h01);
    i_lsc_lin_master.head(2 * BT, BT, p);
    i_lsc_lin_master.get(BT, r);
    chk("tx byte 0", d0, r); // first byte
    i_lsc_lin_master.get(BT, r);
    chk("tx byte 1", d1, r); // second byte
    i_lsc_lin_master.get(BT, r);
    chk("tx checksum", csum(p, d0, d1), r); // checksum follows
    rd(ADDR_ERRLOG, 8'h00); // echoed stop level
    // Let the frame end, so its done event is not mistaken for the serial one
    repeat (BT) @(posedge core_clk_i);
    wr(ADDR_IRQ_STAT, 8'hff);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_COUNT, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    repeat (4) @(posedge core_clk_i);
    rd(ADDR_IRQ_STAT, 8'h01); // plain serial start
    wr(ADDR_COUNT, 8'h01);
    wr(ADDR_CTRL, 8'h01);
    i_lsc_lin_master.get(BT, r);
    chk("serial byte", d0, r); // plain serial transmit
    repeat (2) @(posedge core_clk_i);
    complete_run();
  end
endmodule : lsc_link_ctrl_tb_top
